// ---- rtl/usb_endpoint_pipe.sv ----
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - endpoints 4 to 11 are served by this engine with no controller.
// - each endpoint has an 18-bit base and 16-bit size and offsets.
// - memory moves only whole 16-bit words, so 64 bytes are 32 words.
// - the engine owns OUT write offsets and IN read offsets.
// - both offsets start at zero and wrap to zero at the buffer end.
// - an OUT packet that fits is acknowledged and its offset stored.
// - an OUT packet that would meet the read pointer is NAKed unstored.
// - an OUT packet over the max packet is taken if it fits.
// - a full IN packet is sent and the read offset moves on ACK only.
// - a short IN packet is NAKed up to the 4-bit limit, then sent.
module usb_endpoint_pipe (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // token from the usb core
  input  wire logic        tokValid,
  output logic             tokReady,
  input  wire logic        tokIsIn,
  input  wire logic [3:0]  tokEp,
  // out packet words from the usb core
  input  wire logic        outWordValid,
  output logic             outWordReady,
  input  wire logic [15:0] outWordData,
  input  wire logic        outWordLast,
  // in packet words to the usb core
  output logic             inWordValid,
  input  wire logic        inWordReady,
  output logic      [15:0] inWordData,
  output logic             inWordLast,
  input  wire logic        hostAck,
  input  wire logic        hostLost,
  // handshake decision
  output logic             respValid,
  output usb_pipe_pkg::resp_e respKind,
  // dsp memory port
  output logic             memReq,
  output logic             memWrite,
  output logic      [17:0] memAddr,
  output logic      [15:0] memWdata,
  input  wire logic        memAck,
  input  wire logic [15:0] memRdata
);

  localparam int AW = usb_pipe_pkg::ADDR_W;
  localparam int OW = usb_pipe_pkg::OFF_W;
  localparam int IW = usb_pipe_pkg::EP_IDX_W;
  localparam int NE = usb_pipe_pkg::NUM_EP;

  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_OUT_RUN,
    ST_OUT_WR,
    ST_OUT_END,
    ST_IN_EVAL,
    ST_IN_READ,
    ST_IN_SEND,
    ST_IN_WAIT,
    ST_RESP
  } state_e;

  // next position on the ring, wrapping to zero at the end
  function automatic logic [OW-1:0] ringNext(input logic [OW-1:0] p,
                                             input logic [OW-1:0] sz);
    ringNext = (p + 1'b1 >= sz) ? '0 : OW'(p + 1'b1);
  endfunction : ringNext

  // words held between read and write offsets; equal means empty
  function automatic logic [OW-1:0] ringUsed(input logic [OW-1:0] wr,
                                             input logic [OW-1:0] rd,
                                             input logic [OW-1:0] sz);
    ringUsed = (wr >= rd) ? OW'(wr - rd) : OW'(sz - rd + wr);
  endfunction : ringUsed

  logic [AW-1:0]  baseQ   [NE];
  logic [OW-1:0]  sizeQ   [NE];
  logic [OW-1:0]  rdOffQ  [NE];
  logic [OW-1:0]  wrOffQ  [NE];
  logic [31:0]    ctrlQ   [NE];
  logic [usb_pipe_pkg::NAK_W-1:0] nakCntQ [NE];

  state_e              stateQ;
  logic [IW-1:0]       epQ;
  logic [OW-1:0]       ptrQ;
  logic [OW-1:0]       remainQ;
  logic                nakQ;
  logic                lastQ;
  logic                zlpQ;
  logic [15:0]         wordQ;
  usb_pipe_pkg::resp_e respKindQ;
  logic [31:0]         prdataQ;
  logic                slverrQ;

  logic                fifoValid;
  logic                fifoPop;
  logic [usb_pipe_pkg::FIFO_W-1:0] fifoData;
  logic                hwWrCommit;
  logic                hwRdCommit;
  logic                nakInc;
  logic                nakClr;
  logic                swWrite;
  logic                decOk;
  logic [IW-1:0]       decEp;
  logic [2:0]          decReg;
  logic [IW-1:0]       tokIdx;
  logic                tokInRange;
  logic [OW-1:0]       curSize;
  logic [OW-1:0]       curAvail;
  logic [OW-1:0]       curMps;
  logic [usb_pipe_pkg::NAK_W-1:0] curLimit;
  logic                inOn;
  logic                inFull;
  logic                inHold;

  // out words are staged so the core can stream while memory stalls
  sync_fifo #(
    .WIDTH (usb_pipe_pkg::FIFO_W),
    .DEPTH (usb_pipe_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (outWordValid),
    .inReady  (outWordReady),
    .inData   ({outWordLast, outWordData}),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // apb decode
  assign decEp   = paddr[usb_pipe_pkg::EP_SEL_LSB +: IW];
  assign decReg  = paddr[usb_pipe_pkg::REG_SEL_LSB +: 3];
  assign decOk   = (paddr[11:usb_pipe_pkg::PAGE_LSB]
                    == usb_pipe_pkg::PAGE_ZERO)
                && (decReg <= usb_pipe_pkg::REG_STATUS);
  assign swWrite = psel && penable && pwrite && decOk;
  assign pready  = 1'b1;
  assign prdata  = prdataQ;
  assign pslverr = slverrQ && psel && penable;

  // read data is captured in the setup cycle so the access phase has no wait
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdataQ <= 32'h00000000;
      slverrQ <= 1'b0;
    end
    else if (psel && !penable)
    begin
      slverrQ <= !decOk;
      prdataQ <= 32'h00000000;
      if (decOk && !pwrite)
      begin
        unique case (decReg)
          usb_pipe_pkg::REG_BASE:      prdataQ <= 32'(baseQ[decEp]);
          usb_pipe_pkg::REG_SIZE:      prdataQ <= 32'(sizeQ[decEp]);
          usb_pipe_pkg::REG_RD_OFFSET: prdataQ <= 32'(rdOffQ[decEp]);
          usb_pipe_pkg::REG_WR_OFFSET: prdataQ <= 32'(wrOffQ[decEp]);
          usb_pipe_pkg::REG_CTRL:      prdataQ <= ctrlQ[decEp];
          default:
          begin
            prdataQ[usb_pipe_pkg::STAT_NAKCNT_LSB +: usb_pipe_pkg::NAK_W]
              <= nakCntQ[decEp];
            prdataQ[usb_pipe_pkg::STAT_BUSY_BIT]
              <= (stateQ != ST_IDLE) && (epQ == decEp);
          end
        endcase
      end
    end
  end

  // per-endpoint buffer registers; a hardware commit wins over a
  // software write to the same offset in the same cycle
  for (genvar e = 0; e < NE; e++)
  begin : g_ep
    logic hit;
    logic mine;
    assign hit  = swWrite && (decEp == IW'(e));
    assign mine = (epQ == IW'(e));

    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        baseQ[e] <= usb_pipe_pkg::BASE_RST;
        sizeQ[e] <= usb_pipe_pkg::OFF_RST;
        ctrlQ[e] <= usb_pipe_pkg::CTRL_RST;
      end
      else if (hit)
      begin
        if (decReg == usb_pipe_pkg::REG_BASE)
        begin
          baseQ[e] <= pwdata[AW-1:0];
        end
        if (decReg == usb_pipe_pkg::REG_SIZE)
        begin
          sizeQ[e] <= pwdata[OW-1:0];
        end
        if (decReg == usb_pipe_pkg::REG_CTRL)
        begin
          ctrlQ[e] <= pwdata;
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        rdOffQ[e] <= usb_pipe_pkg::OFF_RST;
        wrOffQ[e] <= usb_pipe_pkg::OFF_RST;
      end
      else
      begin
        if (hwRdCommit && mine)
        begin
          rdOffQ[e] <= ptrQ;
        end
        else if (hit && decReg == usb_pipe_pkg::REG_RD_OFFSET)
        begin
          rdOffQ[e] <= pwdata[OW-1:0];
        end
        if (hwWrCommit && mine)
        begin
          wrOffQ[e] <= ptrQ;
        end
        else if (hit && decReg == usb_pipe_pkg::REG_WR_OFFSET)
        begin
          wrOffQ[e] <= pwdata[OW-1:0];
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        nakCntQ[e] <= usb_pipe_pkg::NAK_RST;
      end
      else if (mine && nakClr)
      begin
        nakCntQ[e] <= usb_pipe_pkg::NAK_RST;
      end
      else if (mine && nakInc)
      begin
        nakCntQ[e] <= nakCntQ[e] + 1'b1;
      end
    end
  end

  // token decode and the current endpoint's view
  assign tokInRange = (tokEp >= usb_pipe_pkg::FIRST_EP)
                   && (tokEp <= usb_pipe_pkg::LAST_EP);
  assign tokIdx   = IW'(tokEp - usb_pipe_pkg::FIRST_EP);
  assign tokReady = (stateQ == ST_IDLE);
  assign curSize  = sizeQ[epQ];
  assign curAvail = ringUsed(wrOffQ[epQ], rdOffQ[epQ], curSize);
  assign curMps   = OW'(ctrlQ[epQ][usb_pipe_pkg::CTRL_MPS_LSB +:
                                   usb_pipe_pkg::MPS_W]);
  assign curLimit = ctrlQ[epQ][usb_pipe_pkg::CTRL_NAKLIM_LSB +:
                               usb_pipe_pkg::NAK_W];

  // handshake and memory outputs
  assign fifoPop     = (stateQ == ST_OUT_RUN) && fifoValid;
  assign memReq      = (stateQ == ST_OUT_WR) || (stateQ == ST_IN_READ);
  assign memWrite    = (stateQ == ST_OUT_WR);
  assign memAddr     = AW'(baseQ[epQ] + AW'(ptrQ));
  assign memWdata    = wordQ;
  assign inWordValid = (stateQ == ST_IN_SEND);
  assign inWordData  = wordQ;
  assign inWordLast  = (remainQ == '0);
  assign respValid   = (stateQ == ST_RESP);
  assign respKind    = respKindQ;
  assign hwWrCommit  = (stateQ == ST_OUT_END) && !nakQ;
  assign hwRdCommit  = (stateQ == ST_IN_WAIT) && hostAck;
  // decided from this token's state: respKindQ still holds the last answer
  assign inOn        = ctrlQ[epQ][usb_pipe_pkg::CTRL_EN_BIT]
                    && ctrlQ[epQ][usb_pipe_pkg::CTRL_DIR_IN_BIT];
  assign inFull      = (curMps != '0) && (curAvail >= curMps);
  assign inHold      = !inFull && (nakCntQ[epQ] < curLimit);
  assign nakInc      = (stateQ == ST_IN_EVAL) && inOn && inHold;
  assign nakClr      = (stateQ == ST_IN_EVAL) && inOn && !inHold;

  // packet sequencer
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stateQ    <= ST_IDLE;
      epQ       <= '0;
      ptrQ      <= usb_pipe_pkg::OFF_RST;
      remainQ   <= usb_pipe_pkg::OFF_RST;
      nakQ      <= 1'b0;
      lastQ     <= 1'b0;
      zlpQ      <= 1'b0;
      wordQ     <= 16'h0000;
      respKindQ <= usb_pipe_pkg::RESP_ACK;
    end
    else
    begin
      unique case (stateQ)
        ST_IDLE:
        begin
          zlpQ <= 1'b0;
          if (tokValid && tokInRange)
          begin
            epQ <= tokIdx;
            if (tokIsIn)
            begin
              stateQ <= ST_IN_EVAL;
            end
            else
            begin
              // a disabled or wrong-way endpoint still drains its data
              ptrQ   <= wrOffQ[tokIdx];
              nakQ   <= !ctrlQ[tokIdx][usb_pipe_pkg::CTRL_EN_BIT]
                     || ctrlQ[tokIdx][usb_pipe_pkg::CTRL_DIR_IN_BIT];
              stateQ <= ST_OUT_RUN;
            end
          end
        end
        ST_OUT_RUN:
        begin
          if (fifoValid)
          begin
            wordQ <= fifoData[usb_pipe_pkg::WORD_W-1:0];
            lastQ <= fifoData[usb_pipe_pkg::WORD_W];
            // no length limit: only room decides, so oversize packets pass
            if (nakQ || ringNext(ptrQ, curSize) == rdOffQ[epQ])
            begin
              nakQ   <= 1'b1;
              stateQ <= fifoData[usb_pipe_pkg::WORD_W] ? ST_OUT_END : ST_OUT_RUN;
            end
            else
            begin
              stateQ <= ST_OUT_WR;
            end
          end
        end
        ST_OUT_WR:
        begin
          if (memAck)
          begin
            ptrQ   <= ringNext(ptrQ, curSize);
            stateQ <= lastQ ? ST_OUT_END : ST_OUT_RUN;
          end
        end
        ST_OUT_END:
        begin
          respKindQ <= nakQ ? usb_pipe_pkg::RESP_NAK : usb_pipe_pkg::RESP_ACK;
          stateQ    <= ST_RESP;
        end
        ST_IN_EVAL:
        begin
          ptrQ <= rdOffQ[epQ];
          if (!ctrlQ[epQ][usb_pipe_pkg::CTRL_EN_BIT]
              || !ctrlQ[epQ][usb_pipe_pkg::CTRL_DIR_IN_BIT])
          begin
            respKindQ <= usb_pipe_pkg::RESP_NAK;
            stateQ    <= ST_RESP;
          end
          else if (curMps != '0 && curAvail >= curMps)
          begin
            remainQ   <= OW'(curMps - 1'b1);
            respKindQ <= usb_pipe_pkg::RESP_ACK;
            stateQ    <= ST_IN_READ;
          end
          else if (nakCntQ[epQ] < curLimit)
          begin
            respKindQ <= usb_pipe_pkg::RESP_NAK;
            stateQ    <= ST_RESP;
          end
          else if (curAvail == '0)
          begin
            respKindQ <= usb_pipe_pkg::RESP_ZLP;
            zlpQ      <= 1'b1;
            stateQ    <= ST_RESP;
          end
          else
          begin
            remainQ   <= OW'(curAvail - 1'b1);
            respKindQ <= usb_pipe_pkg::RESP_ACK;
            stateQ    <= ST_IN_READ;
          end
        end
        ST_IN_READ:
        begin
          if (memAck)
          begin
            wordQ  <= memRdata;
            stateQ <= ST_IN_SEND;
          end
        end
        ST_IN_SEND:
        begin
          if (inWordReady)
          begin
            ptrQ <= ringNext(ptrQ, curSize);
            if (remainQ == '0)
            begin
              stateQ <= ST_IN_WAIT;
            end
            else
            begin
              remainQ <= OW'(remainQ - 1'b1);
              stateQ  <= ST_IN_READ;
            end
          end
        end
        ST_IN_WAIT:
        begin
          // a lost handshake leaves the stored offset so the retry resends
          if (hostAck || hostLost)
          begin
            stateQ <= ST_IDLE;
          end
        end
        ST_RESP:
        begin
          stateQ <= zlpQ ? ST_IN_WAIT : ST_IDLE;
        end
      endcase
    end
  end

endmodule : usb_endpoint_pipe

`default_nettype wire

// ---- rtl/usb_pipe_pkg.sv ----
package usb_pipe_pkg;

  // endpoint range served by the pipe engine
  localparam int          NUM_EP    = 8;
  localparam int          EP_IDX_W  = 3;
  localparam logic [3:0]  FIRST_EP  = 4'h4;
  localparam logic [3:0]  LAST_EP   = 4'hb;

  // widths
  localparam int ADDR_W = 18;
  localparam int OFF_W  = 16;
  localparam int WORD_W = 16;
  localparam int MPS_W  = 7;
  localparam int NAK_W  = 4;

  // staging fifo in front of memory writes: {last, word}
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = WORD_W + 1;

  // register map: paddr[11:8] zero, paddr[7:5] endpoint, paddr[4:2] register
  localparam logic [3:0] PAGE_ZERO     = 4'h0;
  localparam int         PAGE_LSB      = 8;
  localparam int         EP_SEL_LSB    = 5;
  localparam int         REG_SEL_LSB   = 2;
  localparam logic [2:0] REG_BASE      = 3'h0;
  localparam logic [2:0] REG_SIZE      = 3'h1;
  localparam logic [2:0] REG_RD_OFFSET = 3'h2;
  localparam logic [2:0] REG_WR_OFFSET = 3'h3;
  localparam logic [2:0] REG_CTRL      = 3'h4;
  localparam logic [2:0] REG_STATUS    = 3'h5;

  // control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_DIR_IN_BIT = 1;
  localparam int CTRL_MPS_LSB    = 8;
  localparam int CTRL_NAKLIM_LSB = 16;

  // status register fields
  localparam int STAT_NAKCNT_LSB = 0;
  localparam int STAT_BUSY_BIT   = 8;

  // reset values
  localparam logic [ADDR_W-1:0] BASE_RST = 18'h00000;
  localparam logic [OFF_W-1:0]  OFF_RST  = 16'h0000;
  localparam logic [31:0]       CTRL_RST = 32'h00000000;
  localparam logic [NAK_W-1:0]  NAK_RST  = 4'h0;

  typedef enum logic [1:0]
  {
    RESP_ACK,
    RESP_NAK,
    RESP_ZLP
  } resp_e;

endpackage : usb_pipe_pkg

// ---- rtl/sync_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [PTR_W-1:0] headQ;
  logic [PTR_W-1:0] tailQ;
  logic [PTR_W:0]   countQ;
  logic             push;
  logic             pop;

  assign inReady  = (countQ != (PTR_W+1)'(DEPTH));
  assign outValid = (countQ != '0);
  assign outData  = memQ[headQ];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage has no reset: only words below countQ are ever read
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      memQ[tailQ] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      headQ  <= '0;
      tailQ  <= '0;
      countQ <= '0;
    end
    else
    begin
      if (push)
      begin
        tailQ <= (tailQ == PTR_W'(DEPTH - 1)) ? '0 : tailQ + 1'b1;
      end
      if (pop)
      begin
        headQ <= (headQ == PTR_W'(DEPTH - 1)) ? '0 : headQ + 1'b1;
      end
      if (push && !pop)
      begin
        countQ <= countQ + 1'b1;
      end
      else if (pop && !push)
      begin
        countQ <= countQ - 1'b1;
      end
    end
  end

endmodule : sync_fifo

`default_nettype wire

// ---- test/pipe_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module pipe_checker (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tokValid,
  input wire logic        tokReady,
  input wire logic        tokIsIn,
  input wire logic [3:0]  tokEp,
  input wire logic        respValid,
  input wire logic [1:0]  respKind,
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [17:0] memAddr,
  input wire logic        memAck,
  input wire logic        inWordValid,
  input wire logic        inWordReady,
  input wire logic [15:0] inWordData
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_zero_wait;
    psel && penable |-> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("no ready");
  property p_unmapped;
    psel && penable && paddr[11:8] != 4'h0 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("no slverr");
  property p_mapped;
    psel && penable && paddr[11:8] == 4'h0 && paddr[4:2] < 3'h6 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("false slverr");
  property p_resp_pulse;
    respValid |=> !respValid;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse)
    else $error("long resp");
  property p_tok_busy;
    tokValid && tokReady
      && tokEp inside {[usb_pipe_pkg::FIRST_EP:usb_pipe_pkg::LAST_EP]}
      |=> !tokReady;
  endproperty
  a_tok_busy: assert property (p_tok_busy)
    else $error("token while busy");
  property p_out_quiet;
    tokValid && tokReady && !tokIsIn |=> !respValid [*2];
  endproperty
  a_out_quiet: assert property (p_out_quiet)
    else $error("early out resp");
  property p_in_time;
    tokValid && tokReady && tokIsIn
      && tokEp inside {[usb_pipe_pkg::FIRST_EP:usb_pipe_pkg::LAST_EP]}
      |-> ##2 (respValid || memReq);
  endproperty
  a_in_time: assert property (p_in_time)
    else $error("late in resp");
  property p_mem_hold;
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("mem req unstable");
  property p_in_hold;
    inWordValid && !inWordReady |=> inWordValid && $stable(inWordData);
  endproperty
  a_in_hold: assert property (p_in_hold)
    else $error("in word unstable");
  property p_dir;
    memReq && memWrite |-> !inWordValid;
  endproperty
  a_dir: assert property (p_dir)
    else $error("write in stream");

  c_ack: cover property (respValid && respKind == usb_pipe_pkg::RESP_ACK);
  c_nak: cover property (respValid && respKind == usb_pipe_pkg::RESP_NAK);
  c_zlp: cover property (respValid && respKind == usb_pipe_pkg::RESP_ZLP);
endmodule : pipe_checker

bind usb_endpoint_pipe pipe_checker pipe_checker_inst (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .tokValid(tokValid),
  .tokReady(tokReady), .tokIsIn(tokIsIn), .tokEp(tokEp),
  .respValid(respValid), .respKind(respKind), .memReq(memReq),
  .memWrite(memWrite), .memAddr(memAddr), .memAck(memAck),
  .inWordValid(inWordValid), .inWordReady(inWordReady),
  .inWordData(inWordData));

`default_nettype wire

// ---- test/dsp_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dsp_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [17:0] memAddr,
  input  wire logic [15:0] memWdata,
  input  wire logic        slow,
  output logic             memAck,
  output logic      [15:0] memRdata
);
  logic [15:0] mem [1024];
  int          cnt;

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memAck <= 1'b0;
      cnt <= 0;
      memRdata <= 16'h0000;
    end
    else
    begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck)
      begin
        if (cnt >= (slow ? 2 : 0))
        begin
          memAck <= 1'b1;
          cnt <= 0;
          if (memWrite)
            mem[memAddr[9:0]] <= memWdata;
          else
            memRdata <= mem[memAddr[9:0]];
        end
        else
          cnt <= cnt + 1;
      end
    end
  end
endmodule : dsp_mem_model

`default_nettype wire

// ---- test/test_usb_endpoint_circular_buffer_pipe.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_usb_endpoint_circular_buffer_pipe;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        tokValid, tokReady, tokIsIn, outWordValid, outWordReady;
  logic        outWordLast, inWordValid, inWordReady, inWordLast, hostAck;
  logic        hostLost, respValid, memReq, memWrite, memAck, slow, capE;
  logic [3:0]  tokEp;
  logic [11:0] paddr;
  logic [15:0] outWordData, inWordData, memWdata, memRdata;
  logic [17:0] memAddr;
  logic [31:0] pwdata, prdata, capQ;
  usb_pipe_pkg::resp_e respKind, capK;
  int          fails, cmpCount, seed, wrO, rdO, rdI, nakc, want, i, t;
  logic [15:0] img [16];
  logic [15:0] got [$];
  int          outLen [5] = '{4, 4, 6, 2, 1};
  logic [2:0]  cfgR [7] = '{3'h0, 3'h1, 3'h4, 3'h0, 3'h1, 3'h3, 3'h4};
  logic [31:0] cfgD [7] = '{32'h100, 32'h8, 32'h401, 32'h200, 32'h10,
                            32'h6, 32'h20403};

  usb_endpoint_pipe usb_endpoint_pipe_inst (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tokValid(tokValid),
    .tokReady(tokReady), .tokIsIn(tokIsIn), .tokEp(tokEp),
    .outWordValid(outWordValid), .outWordReady(outWordReady),
    .outWordData(outWordData), .outWordLast(outWordLast),
    .inWordValid(inWordValid), .inWordReady(inWordReady),
    .inWordData(inWordData), .inWordLast(inWordLast), .hostAck(hostAck),
    .hostLost(hostLost), .respValid(respValid), .respKind(respKind),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
  dsp_mem_model dsp_mem_model_inst (
    .ref_clk(ref_clk), .rstn(rstn), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .slow(slow), .memAck(memAck),
    .memRdata(memRdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    inWordReady <= 1'($random(seed));
    slow <= 1'($random(seed));
  end

  task automatic give_verdict();
    $display("compares %0d errors %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    cmpCount++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic waitHi(ref logic s);
    int n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      capQ = prdata;
      capE = pslverr;
      capK = respKind;
    end
    while (s !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      fails++;
      give_verdict();
    end
    @(posedge ref_clk);
  endtask : waitHi

  function automatic logic [11:0] ra(int ep, logic [2:0] r);
    return 12'(((ep - 4) << usb_pipe_pkg::EP_SEL_LSB)
      + (int'(r) << usb_pipe_pkg::REG_SEL_LSB));
  endfunction : ra

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    waitHi(pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic rchk(string nm, int ep, logic [2:0] r, logic [31:0] e);
    apb(1'b0, ra(ep, r), 32'h0);
    check(nm, e, capQ);
  endtask : rchk

  task automatic token(logic isIn, int ep);
    tokValid <= 1'b1;
    tokIsIn <= isIn;
    tokEp <= 4'(ep);
    waitHi(tokReady);
    tokValid <= 1'b0;
  endtask : token

  task automatic outPkt(int ep, int n);
    got.delete();
    for (int k = 0; k < n; k++)
    begin
      got.push_back(16'($random(seed)));
      outWordValid <= 1'b1;
      outWordData <= got[k];
      outWordLast <= (k == n - 1);
      waitHi(outWordReady);
    end
    outWordValid <= 1'b0;
    token(1'b0, ep);
    waitHi(respValid);
  endtask : outPkt

  task automatic inPkt(logic lost);
    int n;
    got.delete();
    token(1'b1, 5);
    capK = usb_pipe_pkg::RESP_ACK;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (respValid)
        capK = respKind;
      if (inWordValid && inWordReady)
        got.push_back(inWordData);
    end
    while (!(respValid && respKind != usb_pipe_pkg::RESP_ACK)
      && !(inWordValid && inWordReady && inWordLast) && n < 2000);
    check("in done", 1, n < 2000);
    @(posedge ref_clk);
    if (capK != usb_pipe_pkg::RESP_NAK)
    begin
      hostAck <= !lost;
      hostLost <= lost;
      @(posedge ref_clk);
      hostAck <= 1'b0;
      hostLost <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : inPkt

  initial
  begin
    seed = 57;
    {rstn, psel, penable, pwrite, tokValid, tokIsIn} = '0;
    {outWordValid, outWordLast, hostAck, hostLost} = '0;
    {tokEp, paddr, outWordData, pwdata} = '0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (t = 0; t < 6; t++)
      rchk("reset", 4, 3'(t), 32'h0);
    for (t = 0; t < 4; t++)
    begin
      apb(1'b1, ra(11, 3'(t)), 32'hffffffff);
      rchk("width", 11, 3'(t), t == 0 ? 32'h3ffff : 32'hffff);
    end
    apb(1'b1, 12'h100, 32'h1);
    check("page err", 1, capE);
    apb(1'b1, ra(4, 3'h5), 32'hf);
    rchk("ro status", 4, 3'h5, 32'h0);
    rchk("hole", 4, 3'h6, 32'h0);
    check("hole err", 1, capE);
    for (t = 0; t < 7; t++)
      apb(1'b1, ra(t < 3 ? 4 : 5, cfgR[t]), cfgD[t]);
    for (i = 0; i < 16; i++)
    begin
      img[i] = 16'($random(seed));
      dsp_mem_model_inst.mem[10'h200 + i] = img[i];
    end
    for (t = 0; t < 5; t++)
    begin
      if (t == 2)
      begin
        rdO = 4;
        apb(1'b1, ra(4, 3'h2), 32'h4);
      end
      outPkt(4, outLen[t]);
      want = int'(outLen[t] <= 7 - (wrO - rdO + 8) % 8);
      check("out resp", want != 0 ? usb_pipe_pkg::RESP_ACK
        : usb_pipe_pkg::RESP_NAK, capK);
      for (i = 0; want != 0 && i < outLen[t]; i++)
        check("out data", got[i],
          dsp_mem_model_inst.mem[10'h100 + (wrO + i) % 8]);
      if (want != 0)
        wrO = (wrO + outLen[t]) % 8;
      rchk("out wr", 4, 3'h3, wrO);
    end
    for (t = 0; t < 8; t++)
    begin
      want = (6 - rdI + 16) % 16;
      if (want < 4 && nakc < 2)
        want = -1;
      else if (want >= 4)
        want = 4;
      inPkt(t == 0);
      if (want < 0)
        check("in nak", usb_pipe_pkg::RESP_NAK, capK);
      else
        check("in words", want, got.size());
      for (i = 0; i < want; i++)
        check("in data", img[(rdI + i) % 16], got[i]);
      if (want == 0)
        check("in zlp", usb_pipe_pkg::RESP_ZLP, capK);
      nakc = want < 0 ? nakc + 1 : 0;
      if (t > 0 && want > 0)
        rdI = (rdI + want) % 16;
      rchk("in rd", 5, 3'h2, rdI);
      rchk("naks", 5, 3'h5, nakc);
    end
    outPkt(5, 2);
    check("dir", usb_pipe_pkg::RESP_NAK, capK);
    rchk("dir wr", 5, 3'h3, 32'h6);
    give_verdict();
  end
endmodule : test_usb_endpoint_circular_buffer_pipe

`default_nettype wire
